/* core/wkd_filt_if.sv */
interface wkd_filt_if;
    import wkd_pkg::*;
    logic             level;
    logic             active;
    logic [CNT_W-1:0] limit;
    logic             evt;
    logic             stable;

    modport ctl (output level, output active, output limit,
                 input  evt,   input  stable);
    modport flt (input  level, input  active, input  limit,
                 output evt,   output stable);
endinterface : wkd_filt_if

/* core/wkd_filter.sv */
module wkd_filter
    import wkd_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // filter channel
    wkd_filt_if.flt   ch
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             stable;
        logic             evt;
    } wkd_filt_t;

    wkd_filt_t s_q;
    wkd_filt_t s_d;

    always_comb begin
        s_d     = s_q;
        s_d.evt = 1'b0;
        if (!ch.active) begin
            s_d.cnt = '0;
        end else if (ch.level != s_q.stable) begin
            if (s_q.cnt >= ch.limit - CNT_W'(1)) begin
                s_d.cnt    = '0;
                s_d.stable = ch.level;
                s_d.evt    = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
            end
        end else begin
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ch.evt    = s_q.evt;
    assign ch.stable = s_q.stable;

endmodule : wkd_filter

/* core/wkd_pkg.sv */
// How it works
// - each wake pin raises an event on rising and on falling edges
// - event drives interrupt in normal/stop, wake-up in sleep/fail-safe
// - per-pin static sense (always on) or cyclic sense (window only)
// - filter starts on a level change, accepts if stable for filter time
// - per-pin filter select applies in static and cyclic sense alike
// - per-pin wake enable; a disabled pin makes no wake events
// - each accepted event sets its pin's sticky wake status bit
// - pin level status register shows each pin's present level
// - in cyclic sense the level status shows the last window sample
// - no level readback on pin 4 as pacing input or pin 2 as fail output
// - pull select 00 none, 01 pull-down, 10 pull-up; reset is 00
// - pull select 11 follows the pin: pull-up when high, down when low
// - pin 5 ignores pull select and has its pull-up on at all times outside reset
// - init to normal: static enabled pin already high sets status, irq
// - pin 4 may serve as pacing input for high-side on-times
// - pacing selected on pin 4: its wake bits ignored, no wake-up
package wkd_pkg;

    localparam int          NPINS        = 5;
    localparam int          PACE_PIN     = 3;
    localparam int          FAIL_PIN     = 1;
    localparam int          SUPPLY_PIN   = 4;
    localparam int          CNT_W        = 12;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL0    = 8'h00;
    localparam logic [7:0]  OFS_STAT     = 8'h14;
    localparam logic [7:0]  OFS_MASK     = 8'h18;
    localparam logic [7:0]  OFS_LEVEL    = 8'h1C;
    localparam logic [7:0]  OFS_CONF     = 8'h20;

    // per-pin control register fields, plus the fail output bit of the config register
    localparam int          F_EN_LSB     = 0;
    localparam int          F_CYC        = 2;
    localparam int          F_FILT_LSB   = 3;
    localparam int          F_PULL_LO    = 6;
    localparam int          F_PULL_HI    = 7;
    localparam int          F_FAILOUT    = 0;

    localparam logic [7:0]  RST_CTRL     = 8'h00;
    localparam logic [4:0]  RST_MASK     = 5'h00;
    localparam logic        RST_FAILOUT  = 1'b1;

    localparam logic [1:0]  EN_OFF       = 2'b00;
    localparam logic [1:0]  EN_WAKE      = 2'b01;
    localparam logic [1:0]  EN_PACE      = 2'b10;

    typedef enum logic [2:0] {
        WKD_INIT     = 3'b000,
        WKD_NORMAL   = 3'b001,
        WKD_STOP     = 3'b010,
        WKD_SLEEP    = 3'b011,
        WKD_FAILSAFE = 3'b100
    } wkd_mode_t;

    // filter times in ns and derived cycle counts
    localparam int          CLK_NS       = 100;
    localparam int          FILT_NS0     = 16000;
    localparam int          FILT_NS1     = 32000;
    localparam int          FILT_NS2     = 64000;
    localparam int          FILT_NS3     = 128000;
    localparam int          FILT_NS4     = 192000;
    localparam int          FILT_NS5     = 256000;
    localparam int          FILT_NS6     = 320000;
    localparam int          FILT_NS7     = 384000;

    function automatic logic [CNT_W-1:0] wkd_cyc(input int t_ns);
        wkd_cyc = CNT_W'((t_ns + CLK_NS - 1) / CLK_NS);
    endfunction : wkd_cyc

    function automatic logic [CNT_W-1:0] wkd_filt_cycles(
        input logic [2:0] sel);
        unique case (sel)
            3'd0: wkd_filt_cycles = wkd_cyc(FILT_NS0);
            3'd1: wkd_filt_cycles = wkd_cyc(FILT_NS1);
            3'd2: wkd_filt_cycles = wkd_cyc(FILT_NS2);
            3'd3: wkd_filt_cycles = wkd_cyc(FILT_NS3);
            3'd4: wkd_filt_cycles = wkd_cyc(FILT_NS4);
            3'd5: wkd_filt_cycles = wkd_cyc(FILT_NS5);
            3'd6: wkd_filt_cycles = wkd_cyc(FILT_NS6);
            3'd7: wkd_filt_cycles = wkd_cyc(FILT_NS7);
        endcase
    endfunction : wkd_filt_cycles

endpackage : wkd_pkg

/* core/wkd_top.sv */
// The register offsets and the plain strobed port were chosen for this implementation.
module wkd_top
    import wkd_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // device state
    input  wire logic [2:0]  device_mode,
    input  wire logic        cyclic_window,
    // wake pin comparators
    input  wire logic [4:0]  wake_pin,
    // pull current controls
    output logic      [4:0]  pull_up_en,
    output logic      [4:0]  pull_down_en,
    // events, pacing and fail output select
    output logic             irq,
    output logic             wake_up,
    output logic             pacing_level,
    output logic             fail_safe_output_sel
);

    typedef struct packed {
        logic [NPINS-1:0][7:0] ctrl;
        logic [NPINS-1:0]      stat;
        logic [NPINS-1:0]      mask;
        logic                  failout;
        logic [NPINS-1:0]      samp;
        logic [31:0]           rdata;
        logic [2:0]            mode_prev;
        logic [NPINS-1:0]      sync1;
        logic [NPINS-1:0]      sync2;
        logic                  wake;
        logic                  irq;
        logic                  pace;
        logic [NPINS-1:0]      pu;
        logic [NPINS-1:0]      pd;
    } wkd_state_t;

    wkd_state_t s_q;
    wkd_state_t s_d;

    logic [NPINS-1:0] evt;
    logic [NPINS-1:0] active;
    logic [NPINS-1:0] wake_en;
    logic [NPINS-1:0] cyclic;
    logic [NPINS-1:0] level_view;

    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    function automatic logic is_ctrl(input logic [7:0] a,
                                     input int         idx);
        is_ctrl = (a == OFS_CTRL0 + 8'(idx * 4));
    endfunction : is_ctrl

    // per-pin decode of enable and sense mode
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            wake_en[i] = (s_q.ctrl[i][F_EN_LSB+:2] == EN_WAKE);
            cyclic[i]  = s_q.ctrl[i][F_CYC];
        end
        if (s_q.ctrl[PACE_PIN][F_EN_LSB+:2] == EN_PACE) begin
            wake_en[PACE_PIN] = 1'b0;
            cyclic[PACE_PIN]  = 1'b0;
        end
        if (s_q.failout) begin
            wake_en[FAIL_PIN] = 1'b0;
        end
        for (int i = 0; i < NPINS; i++) begin
            active[i] = wake_en[i] && (!cyclic[i] || cyclic_window);
        end
    end

    // one filter per pin
    generate
        for (genvar g = 0; g < NPINS; g++) begin : g_pin
            wkd_filt_if u_ch ();

            assign u_ch.level  = s_q.sync2[g];
            assign u_ch.active = active[g];
            assign u_ch.limit  =
                wkd_filt_cycles(s_q.ctrl[g][F_FILT_LSB+:3]);
            assign evt[g]      = u_ch.evt;

            wkd_filter u_filt (
                .clock (clock),
                .reset (reset),
                .ch    (u_ch.flt)
            );
        end
    endgenerate

    // level view for readback
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            level_view[i] = cyclic[i] ? s_q.samp[i] : s_q.sync2[i];
        end
        // no readback for pace or fail
        if (s_q.ctrl[PACE_PIN][F_EN_LSB+:2] == EN_PACE) begin
            level_view[PACE_PIN] = 1'b0;
        end
        if (s_q.failout) begin
            level_view[FAIL_PIN] = 1'b0;
        end
    end

    always_comb begin
        logic [NPINS-1:0] set;
        logic [NPINS-1:0] clr;
        logic             ev_mode;
        set     = '0;
        clr     = '0;
        ev_mode = 1'b0;
        s_d     = s_q;

        s_d.sync1 = wake_pin;
        s_d.sync2 = s_q.sync1;

        for (int i = 0; i < NPINS; i++) begin
            if (cyclic_window) begin
                s_d.samp[i] = s_q.sync2[i];
            end
        end

        set = evt & wake_en;

        if (device_mode == WKD_NORMAL && s_q.mode_prev == WKD_INIT) begin
            for (int i = 0; i < NPINS; i++) begin
                if (wake_en[i] && !cyclic[i] && s_q.sync2[i]) begin
                    set[i] = 1'b1;
                end
            end
        end
        s_d.mode_prev = device_mode;

        // register writes
        if (reg_write) begin
            for (int i = 0; i < NPINS; i++) begin
                if (is_ctrl(reg_addr, i)) begin
                    s_d.ctrl[i] = reg_wdata[7:0];
                end
            end
            if (reg_hit(reg_addr, OFS_MASK)) begin
                s_d.mask = reg_wdata[NPINS-1:0];
            end
            if (reg_hit(reg_addr, OFS_CONF)) begin
                s_d.failout = reg_wdata[F_FAILOUT];
            end
        end

        // register reads, data one cycle later
        s_d.rdata = '0;
        if (reg_read) begin
            for (int i = 0; i < NPINS; i++) begin
                if (is_ctrl(reg_addr, i)) begin
                    s_d.rdata[7:0] = s_q.ctrl[i];
                end
            end
            if (reg_hit(reg_addr, OFS_STAT)) begin
                s_d.rdata[NPINS-1:0] = s_q.stat;
                clr = s_q.stat;
            end
            if (reg_hit(reg_addr, OFS_MASK)) begin
                s_d.rdata[NPINS-1:0] = s_q.mask;
            end
            if (reg_hit(reg_addr, OFS_LEVEL)) begin
                s_d.rdata[NPINS-1:0] = level_view;
            end
            if (reg_hit(reg_addr, OFS_CONF)) begin
                s_d.rdata[F_FAILOUT] = s_q.failout;
            end
        end

        s_d.stat = (s_q.stat & ~clr) | set;

        ev_mode  = (device_mode == WKD_NORMAL) ||
                   (device_mode == WKD_STOP);
        s_d.irq  = ev_mode && |(s_d.stat & s_q.mask);
        s_d.wake = (device_mode == WKD_SLEEP ||
                    device_mode == WKD_FAILSAFE) && |set;

        s_d.pace = (s_q.ctrl[PACE_PIN][F_EN_LSB+:2] == EN_PACE) &&
                   s_q.sync2[PACE_PIN];

        // pull current sources
        for (int i = 0; i < NPINS; i++) begin
            unique case ({s_q.ctrl[i][F_PULL_HI], s_q.ctrl[i][F_PULL_LO]})
                2'b00: begin
                    s_d.pu[i] = 1'b0;
                    s_d.pd[i] = 1'b0;
                end
                2'b01: begin
                    s_d.pu[i] = 1'b0;
                    s_d.pd[i] = 1'b1;
                end
                2'b10: begin
                    s_d.pu[i] = 1'b1;
                    s_d.pd[i] = 1'b0;
                end
                2'b11: begin
                    s_d.pu[i] = s_q.sync2[i];
                    s_d.pd[i] = !s_q.sync2[i];
                end
            endcase
        end
        if (s_q.ctrl[PACE_PIN][F_EN_LSB+:2] == EN_PACE) begin
            s_d.pu[PACE_PIN] = 1'b0;
            s_d.pd[PACE_PIN] = 1'b0;
        end
        s_d.pu[SUPPLY_PIN] = 1'b1;
        s_d.pd[SUPPLY_PIN] = 1'b0;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_q           <= '0;
            s_q.ctrl      <= {NPINS{RST_CTRL}};
            s_q.mask      <= RST_MASK;
            s_q.failout   <= RST_FAILOUT;
            s_q.mode_prev <= WKD_INIT;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata            = s_q.rdata;
    assign pull_up_en           = s_q.pu;
    assign pull_down_en         = s_q.pd;
    assign irq                  = s_q.irq;
    assign wake_up              = s_q.wake;
    assign pacing_level         = s_q.pace;
    assign fail_safe_output_sel = s_q.failout;

endmodule : wkd_top

/* dv/wkd_assertions.sv */
module wkd_assertions
    import wkd_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        reset,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    // device state and pins
    input wire logic [2:0]  device_mode,
    input wire logic        cyclic_window,
    input wire logic [4:0]  wake_pin,
    // block outputs
    input wire logic [4:0]  pull_up_en,
    input wire logic [4:0]  pull_down_en,
    input wire logic        irq,
    input wire logic        wake_up,
    input wire logic        pacing_level,
    input wire logic        fail_safe_output_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_pu_fixed;
        !$past(reset) |-> pull_up_en[4];
    endproperty
    a_pu_fixed: assert property (p_pu_fixed)
        else $error("pin 5 pull-up off");
    property p_pd_fixed;
        !pull_down_en[4];
    endproperty
    a_pd_fixed: assert property (p_pd_fixed)
        else $error("pin 5 pull-down on");
    property p_rd_idle;
        !$past(reg_read) |-> reg_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside slot");
    property p_irq_mode;
        irq |-> $past(device_mode) inside {WKD_NORMAL, WKD_STOP};
    endproperty
    a_irq_mode: assert property (p_irq_mode)
        else $error("irq in wrong mode");
    property p_wake_mode;
        wake_up |-> $past(device_mode) inside {WKD_SLEEP, WKD_FAILSAFE};
    endproperty
    a_wake_mode: assert property (p_wake_mode)
        else $error("wake-up in wrong mode");
    property p_wake_pulse;
        wake_up |=> !wake_up;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake-up longer than one cycle");
    property p_pace;
        pacing_level |-> $past(wake_pin[3], 2) || $past(wake_pin[3], 3)
            || $past(wake_pin[3], 4);
    endproperty
    a_pace: assert property (p_pace)
        else $error("pacing level without pin level");
    property p_fo_rst;
        $past(reset) |-> fail_safe_output_sel;
    endproperty
    a_fo_rst: assert property (p_fo_rst)
        else $error("fail output select not set at reset");
endmodule : wkd_assertions

bind wkd_top wkd_assertions i_chk (
    .clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .device_mode(device_mode),
    .cyclic_window(cyclic_window), .wake_pin(wake_pin),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .irq(irq),
    .wake_up(wake_up), .pacing_level(pacing_level),
    .fail_safe_output_sel(fail_safe_output_sel)
);

/* dv/wkd_pins.sv */
module wkd_pins (
    // clock
    input  wire logic       clock,
    // pull controls
    input  wire logic [4:0] pull_up_en,
    input  wire logic [4:0] pull_down_en,
    // pin levels
    output logic      [4:0] wake_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] drv_en  = 5'h0f;
    logic [4:0] drv_val = 5'h00;
    initial wake_pin = 5'h00;
    // switch wins, then pull level, floating pin toggles
    always @(posedge clock) begin
        for (int i = 0; i < 5; i++) begin
            wake_pin[i] <= drv_en[i] ? drv_val[i] : pull_up_en[i] ? 1'b1
                : pull_down_en[i] ? 1'b0 : ~wake_pin[i];
        end
    end
endmodule : wkd_pins

/* dv/wkd_tb_top.sv */
module wkd_tb_top
    import wkd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [2:0]  device_mode = WKD_INIT;
    logic        cyclic_window = 1'b0;
    logic [31:0] reg_rdata;
    logic [4:0]  wake_pin, pull_up_en, pull_down_en;
    logic        irq, wake_up, pacing_level, fail_safe_output_sel;
    int          error_cnt = 0;
    int          checks_done = 0;
    initial begin
        forever #50 clock = ~clock;
    end
    wkd_top i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .device_mode(device_mode),
        .cyclic_window(cyclic_window), .wake_pin(wake_pin),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .irq(irq),
        .wake_up(wake_up), .pacing_level(pacing_level),
        .fail_safe_output_sel(fail_safe_output_sel));
    wkd_pins i_pins (.clock(clock), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .wake_pin(wake_pin));
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd
    task automatic pin(input int i, input logic v);
        @(posedge clock);
        i_pins.drv_en[i] <= 1'b1;
        i_pins.drv_val[i] <= v;
    endtask : pin
    task automatic mode(input logic [2:0] m);
        @(posedge clock);
        device_mode <= m;
    endtask : mode
    task automatic wait_ev(input int lim, output int n);
        n = 0;
        while (irq !== 1'b1 && wake_up !== 1'b1) begin
            cyc(1);
            n++;
            if (n > lim) begin
                error_cnt++;
                close_out();
            end
        end
    endtask : wait_ev
    task automatic t_reset;
        rd(OFS_CTRL0, 32'h0000_0000);
        rd(OFS_CONF, 32'h0000_0001);
        rd(8'h30, 32'h0000_0000);
        check(32'(pull_down_en), 32'h0000_0000);
        check(32'(pull_up_en), 32'h0000_0010);
        $display("reset test done");
    endtask : t_reset
    task automatic t_init;
        int n;
        wr(OFS_MASK, 32'h0000_001f);
        wr(8'h10, 32'h0000_0001);
        rd(OFS_LEVEL, 32'h0000_0010);
        mode(WKD_NORMAL);
        wait_ev(8, n);
        wr(8'h10, 32'h0000_0000);
        rd(OFS_STAT, 32'h0000_0010);
        check(32'(irq), 32'h0000_0000);
        $display("init test done");
    endtask : t_init
    task automatic t_static;
        int n;
        wr(OFS_CTRL0, 32'h0000_0001);
        pin(0, 1'b1);
        wait_ev(200, n);
        check(32'(n >= 160 && n <= 172), 32'h0000_0001);
        rd(OFS_LEVEL, 32'h0000_0011);
        rd(OFS_STAT, 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
        pin(0, 1'b0);
        wait_ev(200, n);
        rd(OFS_STAT, 32'h0000_0001);
        $display("static test done");
    endtask : t_static
    task automatic t_fail;
        wr(8'h04, 32'h0000_0001);
        pin(1, 1'b1);
        cyc(200);
        rd(OFS_LEVEL, 32'h0000_0010);
        rd(OFS_STAT, 32'h0000_0000);
        pin(1, 1'b0);
        wr(OFS_CONF, 32'h0000_0000);
        cyc(200);
        check(32'(fail_safe_output_sel), 32'h0000_0000);
        rd(OFS_STAT, 32'h0000_0000);
        $display("fail output test done");
    endtask : t_fail
    task automatic t_filter;
        int n;
        wr(8'h04, 32'h0000_0009);
        pin(1, 1'b1);
        cyc(250);
        pin(1, 1'b0);
        cyc(400);
        rd(OFS_STAT, 32'h0000_0000);
        pin(1, 1'b1);
        wait_ev(400, n);
        check(32'(n >= 320 && n <= 332), 32'h0000_0001);
        rd(OFS_STAT, 32'h0000_0002);
        wr(8'h04, 32'h0000_0000);
        $display("filter test done");
    endtask : t_filter
    task automatic t_pull;
        pin(2, 1'b1);
        for (int k = 0; k < 4; k++) begin
            wr(8'h08, 32'(k) << 6);
            cyc(6);
            check(32'({pull_up_en[2], pull_down_en[2]}),
                  32'({k[1], k == 1}));
        end
        @(posedge clock);
        i_pins.drv_en[2] <= 1'b0;
        cyc(20);
        check(32'({wake_pin[2], pull_up_en[2]}), 32'h0000_0003);
        pin(2, 1'b0);
        cyc(6);
        check(32'({pull_up_en[2], pull_down_en[2]}), 32'h0000_0001);
        cyc(200);
        rd(OFS_STAT, 32'h0000_0000);
        wr(8'h08, 32'h0000_0000);
        $display("pull test done");
    endtask : t_pull
    task automatic t_pace;
        wr(8'h0C, 32'h0000_0002);
        pin(3, 1'b1);
        cyc(300);
        check(32'(pacing_level), 32'h0000_0001);
        rd(OFS_LEVEL, 32'h0000_0012);
        rd(OFS_STAT, 32'h0000_0000);
        pin(3, 1'b0);
        cyc(6);
        check(32'(pacing_level), 32'h0000_0000);
        wr(8'h0C, 32'h0000_0000);
        $display("pacing test done");
    endtask : t_pace
    task automatic t_cyclic;
        int n;
        wr(OFS_CTRL0, 32'h0000_0005);
        pin(0, 1'b1);
        cyc(300);
        rd(OFS_STAT, 32'h0000_0000);
        @(posedge clock);
        cyclic_window <= 1'b1;
        wait_ev(200, n);
        rd(OFS_STAT, 32'h0000_0001);
        @(posedge clock);
        cyclic_window <= 1'b0;
        pin(0, 1'b0);
        cyc(6);
        rd(OFS_LEVEL, 32'h0000_0013);
        wr(OFS_CTRL0, 32'h0000_0000);
        $display("cyclic test done");
    endtask : t_cyclic
    task automatic t_sleep;
        int n;
        wr(8'h08, 32'h0000_0001);
        mode(WKD_SLEEP);
        pin(2, 1'b1);
        wait_ev(200, n);
        check(32'({irq, wake_up}), 32'h0000_0001);
        rd(OFS_STAT, 32'h0000_0004);
        mode(WKD_FAILSAFE);
        pin(2, 1'b0);
        wait_ev(200, n);
        check(32'({irq, wake_up}), 32'h0000_0001);
        mode(WKD_STOP);
        cyc(2);
        check(32'(irq), 32'h0000_0001);
        rd(OFS_STAT, 32'h0000_0004);
        $display("sleep test done");
    endtask : t_sleep
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_init();
        t_static();
        t_fail();
        t_filter();
        t_pull();
        t_pace();
        t_cyclic();
        t_sleep();
        close_out();
    end
endmodule : wkd_tb_top
